// >>> core/idebm_regs.sv
/*
 * IDE bus-master DMA register block for primary and secondary channels,
 * with a per-channel data buffer that an abort or a fresh start flushes.
 * Assumes the I/O decode, the PCI master engine and the drive-side DMA
 * logic all run on i_core_clk and talk through same-clock signals.
 */
`timescale 1ns/100ps

// Small synchronous FIFO; flush empties it in one cycle
module idebm_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst,
	input  wire logic             i_flush,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic      [WIDTH-1:0] o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW-1:0]    rd_idx;
	logic [CW-1:0]    count;
	logic             push;
	logic             pop;

	// Honest full and empty straight from the count register
	assign o_ready = (count != FULL_CNT);
	assign o_valid = (count != '0);
	assign o_data  = mem[rd_idx];
	assign push    = i_valid && o_ready && !i_flush;
	assign pop     = o_valid && i_ready && !i_flush;

	// Storage needs no reset; only the pointers define contents
	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wr_idx] <= i_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count  <= '0;
		end else if (i_flush) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
			end
			if (pop) begin
				rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
			end
			count <= count + CW'(push) - CW'(pop);
		end
	end
endmodule : idebm_fifo

module idebm_regs #(
	parameter logic SIMPLEX = 1'b0,
	parameter int   DATA_W  = idebm_pkg::DATA_W,
	parameter int   DEPTH   = idebm_pkg::FIFO_DEPTH
) (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst,
	input  wire idebm_pkg::idebm_io_req_s i_io_req,
	output logic                        o_io_ack,
	output logic [31:0]                 o_io_rdata,
	input  wire idebm_pkg::idebm_evt_s  [1:0] i_evt,
	output logic [1:0]                  o_bm_enable,
	output logic [1:0]                  o_bm_write_dir,
	output logic [1:0]                  o_bm_active,
	output logic [1:0]                  o_abort,
	output logic [1:0][31:0]            o_desc_ptr,
	input  wire logic [1:0][DATA_W-1:0] i_src_data,
	input  wire logic [1:0]             i_src_valid,
	output logic [1:0]                  o_src_ready,
	output logic [1:0][DATA_W-1:0]      o_snk_data,
	output logic [1:0]                  o_snk_valid,
	input  wire logic [1:0]             i_snk_ready
);
	// Decode of one channel's dword: ptr=0 command/status, ptr=1 pointer
	function automatic logic hit(input idebm_pkg::idebm_io_req_s r,
	                             input logic ch, input logic ptr);
		hit = r.sel && (r.addr[3] == ch) && (r.addr[2] == ptr);
	endfunction : hit

	logic [1:0][31:0] rd_cs;
	logic [1:0]       flush;

	genvar c;
	generate
		for (c = 0; c < idebm_pkg::NUM_CH; c++) begin : g_ch
			logic cs_wr;
			logic ptr_wr;
			logic start_w;
			logic start_rise;
			logic stop_req;
			logic irq_f;
			logic err_f;
			logic drv0;
			logic drv1;
			logic [7:0] cmd_rd;
			logic [7:0] st_rd;
			logic [31:0] next_ptr;

			assign cs_wr  = i_io_req.wr && hit(i_io_req, 1'(c), 1'b0);
			assign ptr_wr = i_io_req.wr && hit(i_io_req, 1'(c), 1'b1);
			assign start_w = i_io_req.wdata[idebm_pkg::CMD_START];
			// Start edge and stop request seen on the command lane
			assign start_rise = cs_wr && i_io_req.be[idebm_pkg::LANE_CMD]
				&& start_w && !o_bm_enable[c];
			assign stop_req = cs_wr && i_io_req.be[idebm_pkg::LANE_CMD]
				&& !start_w && o_bm_enable[c];
			// Fresh start and abort both drop stale data
			assign flush[c] = start_rise || stop_req;

			// Command bits; direction is stored as written
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					o_bm_enable[c]    <= idebm_pkg::CMD_RESET[0];
					o_bm_write_dir[c] <= idebm_pkg::CMD_RESET[3];
				end else if (cs_wr && i_io_req.be[idebm_pkg::LANE_CMD]) begin
					o_bm_enable[c]    <= start_w;
					o_bm_write_dir[c] <= i_io_req.wdata[idebm_pkg::CMD_DIR];
				end
			end

			// Active flag and abort pulse
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					o_bm_active[c] <= 1'b0;
					o_abort[c]     <= 1'b0;
				end else begin
					o_abort[c] <= stop_req && o_bm_active[c];
					if (start_rise) begin
						o_bm_active[c] <= 1'b1;
					end else if (stop_req || i_evt[c].xfer_done
					             || i_evt[c].err) begin
						o_bm_active[c] <= 1'b0;
					end
				end
			end

			// Sticky irq and error flags (a same-cycle event beats the write-1 clear) and plain drive bits
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					irq_f <= idebm_pkg::STAT_RESET[2];
					err_f <= idebm_pkg::STAT_RESET[1];
					drv0  <= idebm_pkg::STAT_RESET[5];
					drv1  <= idebm_pkg::STAT_RESET[6];
				end else begin
					if (i_evt[c].irq) begin
						irq_f <= 1'b1;
					end else if (cs_wr && i_io_req.be[idebm_pkg::LANE_STAT]
					             && i_io_req.wdata[16 + idebm_pkg::ST_IRQ]) begin
						irq_f <= 1'b0;
					end
					if (i_evt[c].err) begin
						err_f <= 1'b1;
					end else if (cs_wr && i_io_req.be[idebm_pkg::LANE_STAT]
					             && i_io_req.wdata[16 + idebm_pkg::ST_ERR]) begin
						err_f <= 1'b0;
					end
					if (cs_wr && i_io_req.be[idebm_pkg::LANE_STAT]) begin
						drv0 <= i_io_req.wdata[16 + idebm_pkg::ST_DRV0];
						drv1 <= i_io_req.wdata[16 + idebm_pkg::ST_DRV1];
					end
				end
			end

			// Byte-merged pointer write; the low two bits never hold a one
			always_comb begin
				next_ptr = o_desc_ptr[c];
				for (int b = 0; b < 4; b++) begin
					if (i_io_req.be[b]) begin
						next_ptr[8*b +: 8] = i_io_req.wdata[8*b +: 8];
					end
				end
				next_ptr[1:0] = 2'b00;
			end

			// Pointer: software load, else advance per descriptor taken
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					o_desc_ptr[c] <= idebm_pkg::PTR_RESET;
				end else if (ptr_wr) begin
					o_desc_ptr[c] <= next_ptr;
				end else if (i_evt[c].desc_taken && o_bm_active[c]) begin
					o_desc_ptr[c][31:2] <= o_desc_ptr[c][31:2]
						+ idebm_pkg::PTR_STEP;
				end
			end

			// Read images; unused command bits are hard zero
			assign cmd_rd = {4'h0, o_bm_write_dir[c], 2'b00,
			                 o_bm_enable[c]};
			assign st_rd  = {SIMPLEX, drv1, drv0, 2'b00, irq_f, err_f,
			                 o_bm_active[c]};
			assign rd_cs[c] = {8'h00, st_rd, 8'h00, cmd_rd};

			// Data buffer, filled only while the channel is active
			idebm_fifo #(
				.WIDTH (DATA_W),
				.DEPTH (DEPTH)
			) u_fifo (
				.i_core_clk (i_core_clk),
				.i_rst      (i_rst),
				.i_flush    (flush[c]),
				.i_data     (i_src_data[c]),
				.i_valid    (i_src_valid[c] && o_bm_active[c]),
				.o_ready    (o_src_ready[c]),
				.o_data     (o_snk_data[c]),
				.o_valid    (o_snk_valid[c]),
				.i_ready    (i_snk_ready[c])
			);
		end
	endgenerate

	// Registered read answer, one cycle after the request
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_io_ack   <= 1'b0;
			o_io_rdata <= 32'h0000_0000;
		end else begin
			o_io_ack <= i_io_req.sel && (i_io_req.wr || i_io_req.rd);
			if (i_io_req.sel && i_io_req.rd) begin
				o_io_rdata <= i_io_req.addr[2]
					? o_desc_ptr[i_io_req.addr[3]]
					: rd_cs[i_io_req.addr[3]];
			end
		end
	end

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	logic rd_cs_q;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_cs_q <= 1'b0;
		end else begin
			rd_cs_q <= i_io_req.sel && i_io_req.rd && !i_io_req.addr[2];
		end
	end

	property p_cmd_rsv;
		rd_cs_q |-> (o_io_rdata[7:4] == 4'h0) && (o_io_rdata[2:1] == 2'b00)
			&& (o_io_rdata[20:19] == 2'b00);
	endproperty
	a_cmd_rsv: assert property (p_cmd_rsv)
		else $error("reserved command bits read nonzero");

	property p_dir;
		i_io_req.sel && i_io_req.wr && !i_io_req.addr[2] && i_io_req.be[0]
		|=> o_bm_write_dir[$past(i_io_req.addr[3])]
			== $past(i_io_req.wdata[3]);
	endproperty
	a_dir: assert property (p_dir)
		else $error("direction bit not taken from write");

	property p_start;
		g_ch[0].start_rise |=> o_bm_enable[0] && o_bm_active[0];
	endproperty
	a_start: assert property (p_start)
		else $error("start did not activate channel");

	property p_abort;
		g_ch[1].stop_req && o_bm_active[1]
		|=> o_abort[1] && !o_bm_active[1] ##1 !o_abort[1];
	endproperty
	a_abort: assert property (p_abort)
		else $error("stop did not abort for one cycle");

	property p_flush;
		flush[0] |=> !o_snk_valid[0];
	endproperty
	a_flush: assert property (p_flush)
		else $error("buffer not emptied on start or stop");

	property p_irq_set;
		i_evt[0].irq |=> g_ch[0].irq_f [*1] ##0 g_ch[0].st_rd[2];
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("interrupt flag not set");

	property p_err_clr;
		g_ch[1].cs_wr && i_io_req.be[2] && i_io_req.wdata[17]
		&& !i_evt[1].err |=> !g_ch[1].err_f;
	endproperty
	a_err_clr: assert property (p_err_clr)
		else $error("error flag not cleared by write one");

	property p_ptr_step;
		i_evt[0].desc_taken && o_bm_active[0] && !g_ch[0].ptr_wr
		|=> o_desc_ptr[0] == $past(o_desc_ptr[0]) + 32'h0000_0008;
	endproperty
	a_ptr_step: assert property (p_ptr_step)
		else $error("pointer did not advance by eight");

	property p_ptr_low;
		o_desc_ptr[1][1:0] == 2'b00;
	endproperty
	a_ptr_low: assert property (p_ptr_low)
		else $error("pointer low bits nonzero");

	property p_done;
		(i_evt[1].xfer_done || i_evt[1].err) && !g_ch[1].start_rise
		|=> !o_bm_active[1];
	endproperty
	a_done: assert property (p_done)
		else $error("active stayed set after transfer end");

	property p_simplex;
		rd_cs_q |-> o_io_rdata[16 + idebm_pkg::ST_SIMPLEX] == SIMPLEX;
	endproperty
	a_simplex: assert property (p_simplex)
		else $error("simplex bit wrong");

	c_start: cover property (g_ch[0].start_rise ##[1:20] i_evt[0].xfer_done);
	c_abort: cover property (o_abort[1]);
	c_full:  cover property (!o_src_ready[0] && o_bm_active[0]);
	c_error: cover property (i_evt[0].err ##1 g_ch[0].err_f);
endmodule : idebm_regs

// >>> core/idebm_pkg.sv
/*
 * Shared constants and carrier types for the two-channel IDE bus-master
 * register block: register offsets, bit positions, reset values, buffer
 * depth and the packed structs for the I/O request and engine events.
 * Assumes a single core clock and that every user writes package::name.
 */
package idebm_pkg;

	// Channel count and data buffer shape
	localparam int NUM_CH     = 2;
	localparam int FIFO_DEPTH = 4;
	localparam int DATA_W     = 32;

	// Byte offsets from the controller I/O base
	localparam logic [3:0] OFF_PRI_CMD  = 4'h0;
	localparam logic [3:0] OFF_PRI_STAT = 4'h2;
	localparam logic [3:0] OFF_PRI_PTR  = 4'h4;
	localparam logic [3:0] OFF_SEC_CMD  = 4'h8;
	localparam logic [3:0] OFF_SEC_STAT = 4'hA;
	localparam logic [3:0] OFF_SEC_PTR  = 4'hC;

	// Command register bit positions
	localparam int CMD_START = 0;
	localparam int CMD_DIR   = 3;

	// Status register bit positions
	localparam int ST_ACTIVE  = 0;
	localparam int ST_ERR     = 1;
	localparam int ST_IRQ     = 2;
	localparam int ST_DRV0    = 5;
	localparam int ST_DRV1    = 6;
	localparam int ST_SIMPLEX = 7;

	// Byte lane of each register inside its dword
	localparam int LANE_CMD  = 0;
	localparam int LANE_STAT = 2;

	// Reset values and pointer step (8 bytes, counted in dwords)
	localparam logic [7:0]  CMD_RESET  = 8'h00;
	localparam logic [7:0]  STAT_RESET = 8'h00;
	localparam logic [31:0] PTR_RESET  = 32'h0000_0000;
	localparam logic [29:0] PTR_STEP   = 30'h0000_0002;

	// Host I/O request, held for one cycle per access
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} idebm_io_req_s;

	// Per-channel one-cycle event pulses from the transfer engine
	typedef struct packed {
		logic desc_taken;
		logic xfer_done;
		logic irq;
		logic err;
	} idebm_evt_s;

endpackage : idebm_pkg

// >>> testbench/idebm_engine_model.sv
/*
 * Stand-in for the drive and memory side of one channel: engine event
 * pulses, a counting data source and a stallable data sink.
 * Assumes the bench changes its requests at the falling clock edge.
 */
`timescale 1ns/100ps

module idebm_engine_model (
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst,
	input  wire logic                  i_active,
	input  wire idebm_pkg::idebm_evt_s i_req,
	input  wire logic                  i_push,
	input  wire logic                  i_src_ready,
	input  wire logic                  i_drain,
	output idebm_pkg::idebm_evt_s      o_evt,
	output logic [31:0]                o_src_data,
	output logic                       o_src_valid,
	output logic                       o_snk_ready
);
	logic [31:0] word_cnt;

	// Only a running channel fetches descriptors
	assign o_evt = idebm_pkg::idebm_evt_s'(i_req & {i_active, 3'h7});
	// Data flows only while running; idle lines show no stale word
	assign o_src_valid = i_push & i_active;
	assign o_src_data  = o_src_valid ? word_cnt : ~word_cnt;
	assign o_snk_ready = i_drain;

	// Word counter restarts with every run, so a run never resumes
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			word_cnt <= 32'h0000_0000;
		end else if (!i_active) begin
			word_cnt <= 32'h0000_0000;
		end else if (o_src_valid && i_src_ready) begin
			word_cnt <= word_cnt + 32'h0000_0001;
		end
	end
endmodule : idebm_engine_model

// >>> testbench/ide_bus_master_dma_regs_tb_top.sv
/*
 * Self-checking bench for the IDE bus-master register block: register
 * accesses, start/stop, events, pointer advance and the data buffer.
 * Assumes one 100 MHz clock and the engine model on both channels.
 */
`timescale 1ns/100ps

module ide_bus_master_dma_regs_tb_top;
	logic                            clk;
	logic                            rst;
	idebm_pkg::idebm_io_req_s        req;
	logic                            ack;
	logic [31:0]                     rdata;
	idebm_pkg::idebm_evt_s     [1:0] evt_w;
	idebm_pkg::idebm_evt_s     [1:0] req_evt;
	logic [1:0]                      en;
	logic [1:0]                      dir;
	logic [1:0]                      act;
	logic [1:0]                      abort;
	logic [1:0][31:0]                ptr;
	logic [1:0][31:0]                src_d;
	logic [1:0]                      src_v;
	logic [1:0]                      src_r;
	logic [1:0][31:0]                snk_d;
	logic [1:0]                      snk_v;
	logic [1:0]                      snk_r;
	logic [1:0]                      push;
	logic [1:0]                      drain;
	logic [31:0]                     r;
	logic [3:0]                      b;
	int                              errors;
	int                              num_checks;

	idebm_regs dut (.i_core_clk(clk), .i_rst(rst), .i_io_req(req),
		.o_io_ack(ack), .o_io_rdata(rdata), .i_evt(evt_w),
		.o_bm_enable(en), .o_bm_write_dir(dir), .o_bm_active(act),
		.o_abort(abort), .o_desc_ptr(ptr), .i_src_data(src_d),
		.i_src_valid(src_v), .o_src_ready(src_r), .o_snk_data(snk_d),
		.o_snk_valid(snk_v), .i_snk_ready(snk_r));

	// One engine model per channel
	for (genvar g = 0; g < 2; g++) begin : g_eng
		idebm_engine_model eng (.i_core_clk(clk), .i_rst(rst),
			.i_active(act[g]), .i_req(req_evt[g]), .i_push(push[g]),
			.i_src_ready(src_r[g]), .i_drain(drain[g]), .o_evt(evt_w[g]),
			.o_src_data(src_d[g]), .o_src_valid(src_v[g]),
			.o_snk_ready(snk_r[g]));
	end

	// Clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One access; the request is held until the acknowledge is seen
	task automatic io(input logic wr, input logic [3:0] a,
		input logic [3:0] be, input logic [31:0] wd);
		int n;
		@(negedge clk);
		req = '{sel: 1'b1, wr: wr, rd: !wr, addr: a, be: be, wdata: wd};
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ack !== 1'b1 && n < 4);
		r = rdata;
		req = '0;
		if (ack !== 1'b1) begin
			errors++;
			$display("ERROR io_ack expected 1 seen %b", ack);
			end_sim();
		end
	endtask : io

	// One-cycle engine event on a channel
	task automatic pulse(input int c, input logic [3:0] e);
		@(negedge clk);
		req_evt[c] = idebm_pkg::idebm_evt_s'(e);
		@(negedge clk);
		req_evt[c] = '0;
	endtask : pulse

	initial begin
		{req, req_evt, push, drain} = '0;
		errors = 0;
		num_checks = 0;
		rst = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		// Both channels share one layout at their own offsets
		for (int c = 0; c < 2; c++) begin
			b = c ? idebm_pkg::OFF_SEC_CMD : idebm_pkg::OFF_PRI_CMD;
			io(0, b, 4'h0, 32'h0); chk("cmdstat", 32'h0, r);
			io(0, b | 4'h4, 4'h0, 32'h0); chk("ptr", 32'h0, r);
			// Direction only changed while idle
			io(1, b, 4'h1, 32'hFFFF_FFFE);
			io(0, b, 4'h0, 32'h0); chk("cmd", 32'h0000_0008, r);
			chk("dir", 32'h1, dir[c]);
			io(1, b, 4'h1, 32'h0);
			io(1, b, 4'h4, 32'h00FF_0000);
			io(0, b, 4'h0, 32'h0); chk("stat", 32'h0060_0000, r);
			io(1, b | 4'h4, 4'hF, 32'h1234_567F);
			io(0, b | 4'h4, 4'h0, 32'h0); chk("ptr", 32'h1234_567C, r);
			io(1, b, 4'h1, 32'h1);
			chk("en", 32'h1, en[c]);
			io(0, b, 4'h0, 32'h0); chk("run", 32'h0061_0001, r);
			pulse(c, 4'h8);
			io(0, b | 4'h4, 4'h0, 32'h0); chk("ptr", 32'h1234_5684, r);
			chk("ptr_out", 32'h1234_5684, ptr[c]);
			// Two words buffered, then the run is stopped
			push[c] = 1'b1;
			repeat (2) @(negedge clk);
			push[c] = 1'b0;
			chk("snk_v", 32'h1, snk_v[c]);
			io(1, b, 4'h1, 32'h0);
			chk("abort", 32'h1, abort[c]);
			chk("act", 32'h0, act[c]);
			chk("flush", 32'h0, snk_v[c]);
			io(1, b, 4'h1, 32'h1);
			chk("fresh", 32'h0, snk_v[c]);
			// Fill until refused with the sink stalled, then drain in order
			push[c] = 1'b1;
			repeat (idebm_pkg::FIFO_DEPTH + 2) @(negedge clk);
			push[c] = 1'b0;
			chk("full", 32'h0, src_r[c]);
			drain[c] = 1'b1;
			for (int k = 0; k < idebm_pkg::FIFO_DEPTH; k++) begin
				chk("snk_v", 32'h1, snk_v[c]);
				chk("snk_d", k, snk_d[c]);
				@(negedge clk);
			end
			drain[c] = 1'b0;
			chk("empty", 32'h0, snk_v[c]);
			// Interrupt flag: write 0 keeps it, write 1 clears it
			pulse(c, 4'h2);
			io(0, b, 4'h0, 32'h0); chk("irq", 32'h0065_0001, r);
			io(1, b, 4'h4, 32'h0060_0000);
			io(0, b, 4'h0, 32'h0); chk("irq_w0", 32'h0065_0001, r);
			io(1, b, 4'h4, 32'h0064_0000);
			io(0, b, 4'h0, 32'h0); chk("irq_w1", 32'h0061_0001, r);
			// Error sets its flag and ends the run
			pulse(c, 4'h1);
			io(0, b, 4'h0, 32'h0); chk("err", 32'h0062_0001, r);
			io(1, b, 4'h4, 32'h0062_0000);
			io(0, b, 4'h0, 32'h0); chk("err_w1", 32'h0060_0001, r);
			// Normal completion from an aligned table, then start is cleared
			io(1, b, 4'h1, 32'h0);
			io(1, b | 4'h4, 4'hF, 32'h0002_FFF0);
			io(1, b, 4'h1, 32'h1);
			pulse(c, 4'h8);
			chk("ptr_run2", 32'h0002_FFF8, ptr[c]);
			pulse(c, 4'h4);
			chk("done", 32'h0, act[c]);
			io(1, b, 4'h1, 32'h0);
		end
		end_sim();
	end
endmodule : ide_bus_master_dma_regs_tb_top
